// ### common/sertx_pkg.sv
// package: register map, field positions and states of the serial data path
package sertx_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CSA  = 8'h00;
  localparam logic [7:0] ADDR_CSB  = 8'h04;
  localparam logic [7:0] ADDR_CSC  = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CSA_PE   = 2;
  localparam int CSA_DOR  = 3;
  localparam int CSA_FE   = 4;
  localparam int CSA_UDRE = 5;
  localparam int CSA_TXC  = 6;
  localparam int CSA_RXC  = 7;
  localparam int CSB_TX9  = 0;
  localparam int CSB_RX9  = 1;
  localparam int CSB_TXEN = 3;
  localparam int CSB_RXEN = 4;
  localparam int CSB_EIE  = 5;
  localparam int CSB_CIE  = 6;
  localparam int CSC_PEN  = 3;
  localparam int CSC_PODD = 4;
  localparam int CSC_STP2 = 5;
  localparam int CSC_SYNC = 6;
  // receive buffer word: data in [8:0], then status bits
  localparam int RXW_9    = 8;
  localparam int RXW_FE   = 9;
  localparam int RXW_DOR  = 10;
  localparam int RXW_PE   = 11;
  localparam int RXW_W    = 12;
  localparam int RX_DEPTH = 2;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [11:0] BAUD_RST = 12'h00F;
  localparam logic [2:0]  CSZ_RST  = 3'h3;
  localparam logic [2:0]  CSZ_NINE = 3'h7;

  typedef enum logic {SERT_TX_IDLE, SERT_TX_BUSY} sertx_tx_e;
  typedef enum logic [1:0] {SERT_RX_IDLE, SERT_RX_START, SERT_RX_BITS} sertx_rx_e;

endpackage : sertx_pkg

// ### design/sertx_rxfifo.sv
// two-entry receive buffer holding each character with its status bits
`timescale 1ns/1ps
`default_nettype none
module sertx_rxfifo
  import sertx_pkg::*;
#(
  parameter int W     = 12,
  parameter int DEPTH = 2
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_flush,
  input  wire logic         i_push,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_pop,
  output logic      [W-1:0] o_rdata,
  output logic              o_valid,
  output logic              o_full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  wire do_push = i_push & ~o_full;
  wire do_pop  = i_pop & o_valid;

  assign o_valid = (cnt_q != '0);
  assign o_full  = (cnt_q == (AW + 1)'(DEPTH));
  assign o_rdata = mem_q[rp_q];

  // data array needs no reset: it is never read while empty
  always_ff @(posedge i_ref_clk) begin
    if (do_push) begin
      mem_q[wp_q] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= nxt(wp_q);
      if (do_pop) rp_q <= nxt(rp_q);
      cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_last_pop;
    o_valid && i_pop && !i_push && !i_flush && cnt_q == (AW + 1)'(1) |=> !o_valid;
  endproperty
  a_last_pop: assert property (p_last_pop)
    else $error("buffer not empty after last read");

endmodule : sertx_rxfifo
`default_nettype wire

// ### design/sertx_uart.sv
// serial port data path: transmit buffer, flags, framing and receive capture
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sertx_uart
  import sertx_pkg::*;
#(
  parameter int BAUD_W = 12
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rxd,
  input  wire logic        i_shared_clock_pin,
  input  wire logic        i_tx_complete_irq_ack,
  output logic             o_txd,
  output logic             o_txd_oe_n,
  output logic             o_rxd_owned,
  output logic             o_tx_empty_irq,
  output logic             o_tx_complete_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] char_bits(input logic [2:0] s);
    case (s)
      3'h0:    return 4'h5;
      3'h1:    return 4'h6;
      3'h2:    return 4'h7;
      CSZ_NINE: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction : char_bits

  function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
                                  input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) p = p ^ d[i];
    end
    return p;
  endfunction : par_of

  function automatic logic [12:0] build_frame(input logic [8:0] d,
      input logic [3:0] n, input logic pen, input logic odd);
    logic [12:0] f;
    f    = '1;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) f[i+1] = d[i];
    end
    if (pen) f[n+4'h1] = par_of(d, n, odd);
    return f;
  endfunction : build_frame

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic              eie_q, cie_q, rx_en_q, tx_en_q, tx9_q;
  logic [2:0]        csz_q;
  logic              pen_q, podd_q, stp2_q, sync_q;
  logic [BAUD_W-1:0] baud_q;
  logic              tfull_q, txc_q, pop_ok_q;
  logic [8:0]        tbuf_q;
  logic              fifo_valid, fifo_full, fifo_push, fifo_pop;
  logic [RXW_W-1:0]  fifo_head, push_word;

  wire       setup = i_psel & ~i_penable;
  wire       acc   = i_psel & i_penable & o_pready;
  wire       wr    = acc & i_pwrite;
  wire [3:0] nch   = char_bits(csz_q);

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CSA || a == ADDR_CSB || a == ADDR_CSC ||
           a == ADDR_BAUD || a == ADDR_DATA;
  endfunction : mapped

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {eie_q, cie_q, rx_en_q, tx_en_q, tx9_q} <= '0;
      {pen_q, podd_q, stp2_q, sync_q}         <= '0;
      csz_q  <= CSZ_RST;
      baud_q <= BAUD_W'(BAUD_RST);
    end else if (wr && i_paddr == ADDR_CSB) begin
      tx9_q   <= i_pwdata[CSB_TX9];
      tx_en_q <= i_pwdata[CSB_TXEN];
      rx_en_q <= i_pwdata[CSB_RXEN];
      eie_q   <= i_pwdata[CSB_EIE];
      cie_q   <= i_pwdata[CSB_CIE];
    end else if (wr && i_paddr == ADDR_CSC) begin
      csz_q  <= i_pwdata[2:0];
      pen_q  <= i_pwdata[CSC_PEN];
      podd_q <= i_pwdata[CSC_PODD];
      stp2_q <= i_pwdata[CSC_STP2];
      sync_q <= i_pwdata[CSC_SYNC];
    end else if (wr && i_paddr == ADDR_BAUD) begin
      baud_q <= i_pwdata[BAUD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bus answer: zero wait states, data sampled in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (i_paddr)
      ADDR_CSA: begin
        rd_mux[CSA_RXC]  = fifo_valid;
        rd_mux[CSA_TXC]  = txc_q;
        rd_mux[CSA_UDRE] = ~tfull_q;
        rd_mux[CSA_FE]   = fifo_valid & fifo_head[RXW_FE];
        rd_mux[CSA_DOR]  = fifo_valid & fifo_head[RXW_DOR];
        rd_mux[CSA_PE]   = fifo_valid & fifo_head[RXW_PE];
      end
      ADDR_CSB: begin
        rd_mux[CSB_TX9]  = tx9_q;
        rd_mux[CSB_RX9]  = fifo_valid & fifo_head[RXW_9];
        rd_mux[CSB_TXEN] = tx_en_q;
        rd_mux[CSB_RXEN] = rx_en_q;
        rd_mux[CSB_EIE]  = eie_q;
        rd_mux[CSB_CIE]  = cie_q;
      end
      ADDR_CSC:  rd_mux[6:0] = {sync_q, stp2_q, podd_q, pen_q, csz_q};
      ADDR_BAUD: rd_mux[BAUD_W-1:0] = baud_q;
      ADDR_DATA: rd_mux[7:0] = fifo_valid ? fifo_head[7:0] : 8'h00;
      default:   rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      pop_ok_q  <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~mapped(i_paddr);
      o_prdata  <= (setup & ~i_pwrite) ? rd_mux : '0;
      // only a read that saw a character may consume it
      pop_ok_q  <= setup & ~i_pwrite & (i_paddr == ADDR_DATA) & fifo_valid;
    end
  end

  assign fifo_pop = acc & ~i_pwrite & (i_paddr == ADDR_DATA) & pop_ok_q;

  // ----------------------------------------------------------------
  // bit timing: divider, or edges of the shared clock pin
  // ----------------------------------------------------------------
  logic              sclk_q, sclk_prev_q;
  logic [BAUD_W-1:0] tx_tmr_q;
  sertx_tx_e         tx_st_q;
  logic [12:0]       tx_sh_q;
  logic [3:0]        tx_left_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q      <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_q      <= i_shared_clock_pin;
      sclk_prev_q <= sclk_q;
    end
  end
  wire sclk_rise = sclk_q & ~sclk_prev_q;
  wire sclk_fall = ~sclk_q & sclk_prev_q;
  wire tx_tick   = sync_q ? sclk_fall : (tx_tmr_q == '0);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) tx_tmr_q <= '0;
    else if (tx_st_q == SERT_TX_IDLE || tx_tmr_q == '0) tx_tmr_q <= baud_q;
    else tx_tmr_q <= tx_tmr_q - 1'b1;
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  wire tx_on   = ~o_txd_oe_n;
  wire tx_end  = (tx_st_q == SERT_TX_BUSY) & tx_tick & (tx_left_q == 4'h1);
  wire tx_load = tx_on & tfull_q & (tx_st_q == SERT_TX_IDLE | tx_end);
  wire dwr     = wr & (i_paddr == ADDR_DATA);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tbuf_q  <= '0;
      tfull_q <= 1'b0;
    end else if (dwr) begin
      tbuf_q  <= {tx9_q, i_pwdata[7:0]};
      tfull_q <= 1'b1;
    end else if (tx_load) begin
      tfull_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_q   <= SERT_TX_IDLE;
      tx_sh_q   <= '1;
      tx_left_q <= '0;
      o_txd     <= 1'b1;
    end else if (tx_load) begin
      tx_st_q   <= SERT_TX_BUSY;
      tx_sh_q   <= build_frame(tbuf_q, nch, pen_q, podd_q);
      tx_left_q <= 4'h2 + nch + 4'(pen_q) + 4'(stp2_q);
      o_txd     <= 1'b0;
    end else if (tx_end) begin
      tx_st_q <= SERT_TX_IDLE;
      o_txd   <= 1'b1;
    end else if (tx_st_q == SERT_TX_BUSY && tx_tick) begin
      tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
      tx_left_q <= tx_left_q - 4'h1;
      o_txd     <= tx_sh_q[1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_txd_oe_n <= 1'b1;
    else if (tx_en_q) o_txd_oe_n <= 1'b0;
    else if (tx_st_q == SERT_TX_IDLE && !tfull_q) o_txd_oe_n <= 1'b1;
  end

  // a new completion wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) txc_q <= 1'b0;
    else if (tx_end && !tfull_q) txc_q <= 1'b1;
    else if (i_tx_complete_irq_ack || (wr && i_paddr == ADDR_CSA && i_pwdata[CSA_TXC]))
      txc_q <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_empty_irq    <= 1'b0;
      o_tx_complete_irq <= 1'b0;
    end else begin
      o_tx_empty_irq    <= eie_q & ~tfull_q;
      o_tx_complete_irq <= cie_q & txc_q & ~i_tx_complete_irq_ack;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  sertx_rx_e         rx_st_q;
  logic [BAUD_W-1:0] rx_tmr_q;
  logic [3:0]        rx_idx_q;
  logic [8:0]        rdat_q;
  logic              rpar_q, rx_prev_q, rwait_q, ovr_q;
  logic [RXW_W-1:0]  rwait_word_q, word;

  wire [3:0] nrx     = nch + 4'(pen_q);
  wire       rx_tick = sync_q ? sclk_rise : (rx_tmr_q == '0);
  wire       rx_sof  = sync_q ? (sclk_rise & ~i_rxd) : (rx_prev_q & ~i_rxd);
  wire       rx_go   = rx_en_q & (rx_st_q == SERT_RX_IDLE) & rx_sof;
  wire       rx_done = (rx_st_q == SERT_RX_BITS) & rx_tick & (rx_idx_q == nrx);

  always_comb begin
    word            = '0;
    word[8:0]       = rdat_q;
    word[RXW_FE]    = ~i_rxd;
    word[RXW_DOR]   = ovr_q;
    word[RXW_PE]    = pen_q & (rpar_q != par_of(rdat_q, nch, podd_q));
  end

  assign fifo_push = rx_en_q & ((rwait_q & ~fifo_full) | (rx_done & ~fifo_full));
  assign push_word = rwait_q ? rwait_word_q : word;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_q   <= SERT_RX_IDLE;
      rx_tmr_q  <= '0;
      rx_idx_q  <= '0;
      rdat_q    <= '0;
      rpar_q    <= 1'b0;
      rx_prev_q <= 1'b1;
    end else if (!rx_en_q) begin
      rx_st_q   <= SERT_RX_IDLE; // disable is immediate, the frame is dropped
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= i_rxd;
      rx_tmr_q  <= (rx_tmr_q == '0) ? baud_q : rx_tmr_q - 1'b1;
      case (rx_st_q)
        SERT_RX_IDLE: if (rx_go) begin
          rx_st_q  <= sync_q ? SERT_RX_BITS : SERT_RX_START;
          rx_tmr_q <= baud_q >> 1;
          rx_idx_q <= '0;
          rdat_q   <= '0;
        end
        SERT_RX_START: if (rx_tmr_q == '0) begin
          rx_st_q <= i_rxd ? SERT_RX_IDLE : SERT_RX_BITS;
        end
        SERT_RX_BITS: if (rx_done) begin
          rx_st_q <= SERT_RX_IDLE;
        end else if (rx_tick) begin
          if (rx_idx_q < nch) rdat_q[rx_idx_q] <= i_rxd;
          else rpar_q <= i_rxd;
          rx_idx_q <= rx_idx_q + 4'h1;
        end
        default: rx_st_q <= SERT_RX_IDLE;
      endcase
    end
  end

  // a completed frame that finds the buffer full waits in the holding register rwait_word_q
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rwait_q      <= 1'b0;
      rwait_word_q <= '0;
      ovr_q        <= 1'b0;
    end else if (!rx_en_q) begin
      rwait_q <= 1'b0;
      ovr_q   <= 1'b0;
    end else begin
      if (rx_done && (fifo_full || rwait_q)) begin
        rwait_q      <= 1'b1;
        rwait_word_q <= word;
      end else if (fifo_push && rwait_q) begin
        rwait_q <= 1'b0;
      end else if (rx_go && rwait_q && fifo_full) begin
        rwait_q <= 1'b0; // the waiting character is lost
      end
      if (rx_go && rwait_q && fifo_full) ovr_q <= 1'b1;
      // a late store from the waiting slot also counts as a successful move
      else if (fifo_push) ovr_q <= 1'b0;
    end
  end

  sertx_rxfifo #(
    .W     (RXW_W),
    .DEPTH (RX_DEPTH)
  ) u_rxfifo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_flush   (~rx_en_q),
    .i_push    (fifo_push),
    .i_wdata   (push_word),
    .i_pop     (fifo_pop),
    .o_rdata   (fifo_head),
    .o_valid   (fifo_valid),
    .o_full    (fifo_full)
  );

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_rxd_owned <= 1'b0;
    else o_rxd_owned <= rx_en_q;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_frame_end;
    tx_end && !tfull_q;
  endsequence
  sequence s_stop_seen;
    rx_done && !fifo_full && !rwait_q && rx_en_q;
  endsequence

  property p_empty_lvl;
    (eie_q && !tfull_q)[*2] |-> o_tx_empty_irq;
  endproperty
  a_empty_lvl: assert property (p_empty_lvl)
    else $error("empty interrupt not held");
  property p_fill;
    dwr |=> tfull_q ##0 !rd_mux[CSA_UDRE] || i_paddr != ADDR_CSA;
  endproperty
  a_fill: assert property (p_fill)
    else $error("data write did not fill buffer");
  property p_drain;
    tx_load && !dwr |=> !tfull_q ##0 tx_st_q == SERT_TX_BUSY;
  endproperty
  a_drain: assert property (p_drain)
    else $error("buffer not drained on load");
  property p_txc_set;
    s_frame_end |=> txc_q ##1 (o_tx_complete_irq || !cie_q || !txc_q);
  endproperty
  a_txc_set: assert property (p_txc_set)
    else $error("complete flag missed");
  property p_txc_keep;
    txc_q && wr && i_paddr == ADDR_CSA && !i_pwdata[CSA_TXC]
      && !i_tx_complete_irq_ack |=> txc_q;
  endproperty
  a_txc_keep: assert property (p_txc_keep)
    else $error("writing zero cleared complete flag");
  property p_tx_hold;
    !o_txd_oe_n && (tfull_q || tx_st_q == SERT_TX_BUSY) |=> !o_txd_oe_n;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmitter released pin early");
  property p_start_bit;
    tx_load |=> !o_txd ##1 (!o_txd || tx_tick);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame did not begin low");
  property p_capture;
    s_stop_seen |=> fifo_valid && rx_st_q == SERT_RX_IDLE;
  endproperty
  a_capture: assert property (p_capture)
    else $error("frame not moved to buffer");
  property p_overrun;
    rx_go && rwait_q && fifo_full |=> ovr_q && !rwait_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

endmodule : sertx_uart
`default_nettype wire

// ### bench/sertx_remote.sv
// remote serial node: frame sender on the rx line, frame monitor on the tx line
`timescale 1ns/1ps
`default_nettype none
module sertx_remote #(
  parameter int BT = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_txd,
  input  wire logic       i_txd_oe_n,
  input  wire logic [3:0] i_n_bits,
  output logic            o_rxd,
  output logic            o_xck
);
  // ----
  // sender
  // ----
  logic [9:0] cap_q;
  int         cap_cnt = 0;
  initial o_rxd = 1'b1;
  initial o_xck = 1'b0;
  // stp sets the stop level so a frame error can be provoked
  task automatic send(input logic [9:0] bits, input int n, input logic stp);
    o_rxd <= 1'b0;
    repeat (BT) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      o_rxd <= bits[k];
      repeat (BT) @(posedge i_clk);
    end
    o_rxd <= stp;
    repeat (BT) @(posedge i_clk);
    o_rxd <= 1'b1;
    // one idle cycle so a following call never drives the line twice in a step
    @(posedge i_clk);
  endtask : send
  // synchronous frame: start, n data bits, stop, each sampled on a rising clock
  task automatic send_sync(input logic [9:0] bits, input int n);
    for (int k = 0; k <= n + 1; k++) begin
      o_rxd <= (k == 0) ? 1'b0 : (k > n) ? 1'b1 : bits[(k > 0) ? k - 1 : 0];
      repeat (2) @(posedge i_clk);
      o_xck <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_xck <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask : send_sync
  // ----
  // monitor: mid-bit samples; i_n_bits counts data and parity, the stop comes last
  // ----
  always begin
    @(negedge i_txd iff !i_txd_oe_n);
    cap_q = '0;
    repeat (BT / 2) @(posedge i_clk);
    for (int k = 0; k <= i_n_bits; k++) begin
      repeat (BT) @(posedge i_clk);
      cap_q[k] = i_txd;
    end
    cap_cnt++;
  end
endmodule : sertx_remote
`default_nettype wire

// ### bench/sertx_uart_tb.sv
// self-checking bench: apb register access and serial traffic with a remote node
`timescale 1ns/1ps
`default_nettype none
module sertx_uart_tb
  import sertx_pkg::*;
;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        ack = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        rxd;
  logic        txd;
  logic        txd_oe_n;
  logic        rxd_owned;
  logic        eirq;
  logic        cirq;
  logic        shared_clock_pin;
  logic [3:0]  n_bits = 4'h8;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          c0;
  always #2.5 clk = ~clk;
  sertx_uart sertx_uart_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd),
    .i_shared_clock_pin(shared_clock_pin), .i_tx_complete_irq_ack(ack), .o_txd(txd),
    .o_txd_oe_n(txd_oe_n), .o_rxd_owned(rxd_owned), .o_tx_empty_irq(eirq),
    .o_tx_complete_irq(cirq));
  // bit time is BAUD+1 cycles; BAUD is programmed to 3
  sertx_remote #(.BT(4)) sertx_remote_inst (.i_clk(clk), .i_txd(txd),
    .i_txd_oe_n(txd_oe_n), .i_n_bits(n_bits), .o_rxd(rxd), .o_xck(shared_clock_pin));
  // ----
  // tasks
  // ----
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  // one idle edge after release so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_cap;
    c0 = sertx_remote_inst.cap_cnt;
    for (int k = 0; k < 300 && sertx_remote_inst.cap_cnt == c0; k++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : wait_cap
  // ----
  // watchdog
  // ----
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, ADDR_CSA, 0);
    chk("csa_rst", 32'h20, rd);
    apb(0, ADDR_CSB, 0);
    chk("csb_rst", 32'h0, rd);
    apb(0, 8'h14, 0);
    chk("slverr", 32'h1, 32'(err));
    apb(1, ADDR_BAUD, 32'h3);
    apb(1, ADDR_CSB, 32'h20);
    // the interrupt output lags the enable by one registered cycle
    @(posedge clk);
    chk("eirq_on", 32'h1, 32'(eirq));
    apb(1, ADDR_DATA, 32'hA5);
    apb(0, ADDR_CSA, 0);
    chk("csa_full", 32'h0, rd);
    chk("eirq_off", 32'h0, 32'(eirq));
    apb(1, ADDR_CSB, 32'h58);
    wait_cap();
    chk("tx_a5", 32'h1A5, 32'(sertx_remote_inst.cap_q));
    chk("rx_own", 32'h1, 32'(rxd_owned));
    chk("cirq", 32'h1, 32'(cirq));
    apb(1, ADDR_CSA, 32'h40);
    apb(0, ADDR_CSA, 0);
    chk("txc_w1c", 32'h20, rd);
    n_bits <= 4'h9;
    for (int odd = 0; odd < 2; odd++) begin
      apb(1, ADDR_CSC, 32'(8'h0B | (odd << 4)));
      apb(1, ADDR_DATA, 32'h3);
      wait_cap();
      chk("tx_par", 32'(10'h203 | (odd << 8)), 32'(sertx_remote_inst.cap_q));
    end
    chk("cirq2", 32'h1, 32'(cirq));
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    chk("cirq_ack", 32'h0, 32'(cirq));
    apb(1, ADDR_CSC, 32'h27);
    apb(1, ADDR_CSB, 32'h59);
    apb(1, ADDR_DATA, 32'h0);
    apb(1, ADDR_CSB, 32'h51);
    chk("oe_busy", 32'h0, 32'(txd_oe_n));
    wait_cap();
    chk("tx_nine", 32'h300, 32'(sertx_remote_inst.cap_q));
    chk("oe_rel", 32'h1, 32'(txd_oe_n));
    apb(1, ADDR_CSC, 32'h3);
    sertx_remote_inst.send(10'h3C, 8, 1'b1);
    sertx_remote_inst.send(10'h55, 8, 1'b0);
    repeat (8) @(posedge clk);
    apb(0, ADDR_CSA, 0);
    chk("rxc", 32'h1, 32'(rd[CSA_RXC]));
    chk("fe_a", 32'h0, 32'(rd[CSA_FE]));
    apb(0, ADDR_DATA, 0);
    chk("rx_3c", 32'h3C, rd);
    apb(0, ADDR_CSA, 0);
    chk("fe_b", 32'h1, 32'(rd[CSA_FE]));
    apb(0, ADDR_DATA, 0);
    chk("rx_55", 32'h55, rd);
    // four frames unread: two buffered, one waiting, the fourth start overruns
    sertx_remote_inst.send(10'h11, 8, 1'b1);
    sertx_remote_inst.send(10'h22, 8, 1'b1);
    sertx_remote_inst.send(10'h33, 8, 1'b1);
    sertx_remote_inst.send(10'h44, 8, 1'b1);
    repeat (8) @(posedge clk);
    apb(0, ADDR_CSA, 0);
    chk("dor_a", 32'h0, 32'(rd[CSA_DOR]));
    apb(0, ADDR_DATA, 0);
    chk("rx_11", 32'h11, rd);
    apb(0, ADDR_DATA, 0);
    chk("rx_22", 32'h22, rd);
    apb(0, ADDR_CSA, 0);
    chk("dor_b", 32'h1, 32'(rd[CSA_DOR]));
    apb(0, ADDR_DATA, 0);
    chk("rx_44", 32'h44, rd);
    apb(0, ADDR_CSA, 0);
    chk("rx_empty", 32'h0, 32'(rd[CSA_RXC]));
    apb(1, ADDR_CSC, 32'h43);
    sertx_remote_inst.send_sync(10'h96, 8);
    repeat (4) @(posedge clk);
    apb(0, ADDR_DATA, 0);
    chk("rx_sync", 32'h96, rd);
    apb(1, ADDR_CSC, 32'h0);
    sertx_remote_inst.send(10'h3FF, 5, 1'b1);
    repeat (8) @(posedge clk);
    apb(0, ADDR_CSA, 0);
    chk("dor_c", 32'h0, 32'(rd[CSA_DOR]));
    apb(0, ADDR_DATA, 0);
    chk("rx_5bit", 32'h1F, rd);
    test_done();
  end
endmodule : sertx_uart_tb
`default_nettype wire
